// file: lbam_top.sv
`timescale 1ns/1ps
`include "lbam_consts.svh"

// Functional notes
// [RULE_01] Each 128 ms cycle, failure adds one
// [RULE_02] Leak one per 1/2/4/8 clean cycles
// [RULE_03] Alarm raised when count reaches set level
// [RULE_04] Set level 1..255, resets to six
// [RULE_05] Alarm cleared when count falls to clear level
// [RULE_06] Count never exceeds cap; cap resets eight
// [RULE_07] Alarm holds between the two levels
module lbam_top
#(
	parameter int N_INPUTS = 14,
	parameter int CYCLE_CLKS = `LBAM_CYCLE_CLKS
)
(
	input wire logic clk,
	input wire logic rstn,
	// Per-input failure or erratic indication, asynchronous
	input wire logic [N_INPUTS-1:0] fail_in,
	// Per-input inactivity alarm
	output logic [N_INPUTS-1:0] alarm_out,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	// Word index of a byte address
	function automatic logic [9:0] word_idx(input logic [11:0] a);
		word_idx = a[11:2];
	endfunction

	// True when the address names a mapped register
	function automatic logic is_mapped(input logic [11:0] a);
		logic [9:0] i;
		i = word_idx(a);
		is_mapped = (i == 10'(`LBAM_IDX_SET_LVL)) ||
			(i == 10'(`LBAM_IDX_CLR_LVL)) ||
			(i == 10'(`LBAM_IDX_CAP)) ||
			(i == 10'(`LBAM_IDX_DECAY)) ||
			(i == 10'(`LBAM_IDX_ALARM));
	endfunction

	// Input synchronisers
	logic [N_INPUTS-1:0] fail_s1_q; // First stage, read only by second
	logic [N_INPUTS-1:0] fail_s2_q; // Second stage, safe to use

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			fail_s1_q <= '0;
			fail_s2_q <= '0;
		end
		else
		begin
			fail_s1_q <= fail_in;
			fail_s2_q <= fail_s1_q;
		end
	end

	// Sampling cycle timer
	logic [31:0] tmr_q, tmr_d; // Clocks into current cycle
	logic tick_q, tick_d; // One-clock pulse at cycle end

	always_comb
	begin
		tmr_d = tmr_q + 32'h1;
		tick_d = 1'b0;
		if (tmr_q == 32'(CYCLE_CLKS - 1))
		begin
			tmr_d = 32'h0;
			tick_d = 1'b1; // [RULE_01]
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			tmr_q <= 32'h0;
			tick_q <= 1'b0;
		end
		else
		begin
			tmr_q <= tmr_d;
			tick_q <= tick_d;
		end
	end

	// Failure seen anywhere in the current cycle
	logic [N_INPUTS-1:0] seen_q, seen_d; // Sticky per cycle
	logic [N_INPUTS-1:0] bad_now; // Verdict for the ending cycle

	always_comb
	begin
		bad_now = seen_q | fail_s2_q;
		// A failure in the closing clock opens the next cycle
		seen_d = tick_q ? fail_s2_q : bad_now; // [RULE_01]
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			seen_q <= '0;
		else
			seen_q <= seen_d;
	end

	// Configuration registers
	lbam_pkg::lbam_byte_t set_lvl_q, set_lvl_d; // Alarm set level
	lbam_pkg::lbam_byte_t clr_lvl_q, clr_lvl_d; // Alarm clear level
	lbam_pkg::lbam_byte_t cap_q, cap_d; // Accumulator cap
	lbam_pkg::lbam_decay_t decay_q, decay_d; // Leak run selector

	// Write channel state
	logic [11:0] waddr_q, waddr_d; // Held write address
	logic [7:0] wbyte_q, wbyte_d; // Held low data byte
	logic wlane_q, wlane_d; // Low byte lane enabled
	logic aw_full_q, aw_full_d; // Address taken
	logic w_full_q, w_full_d; // Data taken
	logic awready_q, awready_d;
	logic wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;

	// Write path: take address and data in any order, then commit
	always_comb
	begin
		waddr_d = waddr_q;
		wbyte_d = wbyte_q;
		wlane_d = wlane_q;
		aw_full_d = aw_full_q;
		w_full_d = w_full_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		set_lvl_d = set_lvl_q;
		clr_lvl_d = clr_lvl_q;
		cap_d = cap_q;
		decay_d = decay_q;
		if (s_axi_awvalid && awready_q)
		begin
			waddr_d = s_axi_awaddr;
			aw_full_d = 1'b1;
		end
		if (s_axi_wvalid && wready_q)
		begin
			wbyte_d = s_axi_wdata[7:0];
			wlane_d = s_axi_wstrb[0];
			w_full_d = 1'b1;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (aw_full_q && w_full_q && !bvalid_q)
		begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = is_mapped(waddr_q) ? `LBAM_RESP_OKAY :
				`LBAM_RESP_SLVERR;
			if (wlane_q)
			begin
				unique case (word_idx(waddr_q))
					10'(`LBAM_IDX_SET_LVL):
						// Zero is outside the range; keep old value
						if (wbyte_q != 8'h00)
							set_lvl_d = wbyte_q; // [RULE_04]
					10'(`LBAM_IDX_CLR_LVL):
						clr_lvl_d = wbyte_q; // [RULE_05]
					10'(`LBAM_IDX_CAP):
						if (wbyte_q != 8'h00)
							cap_d = wbyte_q; // [RULE_06]
					10'(`LBAM_IDX_DECAY):
						decay_d = wbyte_q[`LBAM_DECAY_W-1:0]; // [RULE_02]
					default:
						// Read-only or unmapped: no effect
						decay_d = decay_q;
				endcase
			end
		end
		// Ready only while the slot is empty and no response waits
		awready_d = !aw_full_d && !bvalid_d;
		wready_d = !w_full_d && !bvalid_d;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			waddr_q <= 12'h000;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `LBAM_RESP_OKAY;
			set_lvl_q <= `LBAM_RST_SET_LVL; // [RULE_04]
			clr_lvl_q <= `LBAM_RST_CLR_LVL;
			cap_q <= `LBAM_RST_CAP; // [RULE_06]
			decay_q <= `LBAM_RST_DECAY;
		end
		else
		begin
			waddr_q <= waddr_d;
			wbyte_q <= wbyte_d;
			wlane_q <= wlane_d;
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			set_lvl_q <= set_lvl_d;
			clr_lvl_q <= clr_lvl_d;
			cap_q <= cap_d;
			decay_q <= decay_d;
		end
	end

	// Buckets, one per monitored input
	logic [N_INPUTS-1:0] alarm_w; // Alarm of each bucket

	for (genvar g = 0; g < N_INPUTS; g++)
	begin : g_bucket
		lbam_bucket u_bucket
		(
			.clk(clk),
			.rstn(rstn),
			.tick(tick_q),
			.bad(bad_now[g]),
			.set_lvl(set_lvl_q),
			.clr_lvl(clr_lvl_q),
			.cap(cap_q),
			.decay_sel(decay_q),
			.acc(),
			.alarm(alarm_w[g])
		);
	end

	// Read channel state
	logic arready_q, arready_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	// Read path: one answer per request, data from current state
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && arready_q)
		begin
			rvalid_d = 1'b1;
			rresp_d = is_mapped(s_axi_araddr) ? `LBAM_RESP_OKAY :
				`LBAM_RESP_SLVERR;
			unique case (word_idx(s_axi_araddr))
				10'(`LBAM_IDX_SET_LVL):
					rdata_d = {24'h0, set_lvl_q};
				10'(`LBAM_IDX_CLR_LVL):
					rdata_d = {24'h0, clr_lvl_q};
				10'(`LBAM_IDX_CAP):
					rdata_d = {24'h0, cap_q};
				10'(`LBAM_IDX_DECAY):
					rdata_d = {30'h0, decay_q};
				10'(`LBAM_IDX_ALARM):
					rdata_d = 32'(alarm_out);
				default:
					rdata_d = 32'h0;
			endcase
		end
		arready_d = !rvalid_d;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= `LBAM_RESP_OKAY;
			alarm_out <= '0;
		end
		else
		begin
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			alarm_out <= alarm_w; // [RULE_03]
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

endmodule

// file: lbam_consts.svh
`ifndef LBAM_CONSTS_SVH
`define LBAM_CONSTS_SVH

// Register indices; byte address is four times the index
`define LBAM_IDX_SET_LVL 8'h5c
`define LBAM_IDX_CLR_LVL 8'h5d
`define LBAM_IDX_CAP 8'h5e
`define LBAM_IDX_DECAY 8'h5f
`define LBAM_IDX_ALARM 8'h80

// Reset values
`define LBAM_RST_SET_LVL 8'h06
`define LBAM_RST_CLR_LVL 8'h04
`define LBAM_RST_CAP 8'h08
`define LBAM_RST_DECAY 2'h1

// Field layout of the decay register
`define LBAM_DECAY_W 2

// Sampling cycle and clock rate
`define LBAM_CYCLE_MS 128
`define LBAM_CLK_HZ 10000000
`define LBAM_CYCLE_CLKS (`LBAM_CYCLE_MS * (`LBAM_CLK_HZ / 1000))

// Bus responses
`define LBAM_RESP_OKAY 2'h0
`define LBAM_RESP_SLVERR 2'h2

`endif

// file: lbam_pkg.sv
package lbam_pkg;

	// One configuration byte
	typedef logic [7:0] lbam_byte_t;

	// Decay run selector: 1, 2, 4 or 8 clean cycles
	typedef logic [1:0] lbam_decay_t;

	// Bus response code
	typedef logic [1:0] lbam_resp_t;

endpackage

// file: lbam_bucket.sv
`timescale 1ns/1ps
`include "lbam_consts.svh"

// One leaky-bucket accumulator with hysteretic inactivity alarm
module lbam_bucket
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic bad,
	input wire lbam_pkg::lbam_byte_t set_lvl,
	input wire lbam_pkg::lbam_byte_t clr_lvl,
	input wire lbam_pkg::lbam_byte_t cap,
	input wire lbam_pkg::lbam_decay_t decay_sel,
	output lbam_pkg::lbam_byte_t acc,
	output logic alarm
);

	lbam_pkg::lbam_byte_t acc_q, acc_d; // Accumulator count
	logic [3:0] run_q, run_d; // Clean cycles since last leak or failure
	logic alarm_q, alarm_d; // Inactivity alarm
	logic [3:0] run_len; // Clean cycles per leak

	// Next state: count and run step once per sampling cycle, clamp and alarm every clock
	always_comb
	begin
		run_len = 4'h1 << decay_sel;
		acc_d = acc_q;
		run_d = run_q;
		alarm_d = alarm_q;
		if (tick)
		begin
			if (bad)
			begin
				// Failed cycle: climb by one
				run_d = 4'h0;
				if (acc_q < cap)
					acc_d = acc_q + 8'h01; // [RULE_01]
			end
			else if (run_q + 4'h1 >= run_len)
			begin
				// Run complete: leak by one
				run_d = 4'h0;
				if (acc_q != 8'h00)
					acc_d = acc_q - 8'h01; // [RULE_02]
			end
			else
				run_d = run_q + 4'h1; // [RULE_02]
		end
		// Never above the cap, even if the cap was lowered
		if (acc_d > cap)
			acc_d = cap; // [RULE_06]
		// Set at upper level, clear at lower, hold between
		if (acc_d >= set_lvl)
			alarm_d = 1'b1; // [RULE_03] [RULE_07]
		else if (acc_d <= clr_lvl)
			alarm_d = 1'b0; // [RULE_05] [RULE_07]
	end

	// Register state
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			acc_q <= 8'h00;
			run_q <= 4'h0;
			alarm_q <= 1'b0;
		end
		else
		begin
			acc_q <= acc_d;
			run_q <= run_d;
			alarm_q <= alarm_d;
		end
	end

	assign acc = acc_q;
	assign alarm = alarm_q;

endmodule

// file: lbam_top_properties.sv
`timescale 1ns/1ps
// Watches the register port handshakes of the monitor
module lbam_chk
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	// One domain, so one clock and one reset for all
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// Write answered two edges after both channels are taken
	wr_lat_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late or missing");
	// Read answered on the next edge
	rd_lat_a: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read data late or missing");
	// Response withdrawn once taken
	wr_drop_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("write response repeated");
	rd_drop_a: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read data repeated");
	// No new request accepted while an answer waits
	wr_block_a: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during response");
	// Write channels reopen as the response leaves
	wr_back_a: assert property (s_axi_bvalid && s_axi_bready
		|=> s_axi_awready && s_axi_wready)
		else $error("write channels stay closed");
	// Byte fields and status read with zero upper bits
	rd_width_a: assert property (
		s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
		else $error("read data upper bits set");
endmodule

bind lbam_top lbam_chk u_chk (.clk, .rstn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata);

// file: lbam_src.sv
`timescale 1ns/1ps
// Monitored sources: a source told to misbehave shows a failure
module lbam_src
(
	input wire logic clk,
	input wire logic [13:0] bad,
	output logic [13:0] fail_in
);
	// Failure level follows the command one clock later
	always_ff @(posedge clk)
		fail_in <= bad;
endmodule

// file: tb.sv
`timescale 1ns/1ps
`define CK(n,e,g) begin checks_done++; if ((g) !== (e)) begin \
mismatches++; $display("BAD %s exp %0h got %0h", n, e, g); end end
// Bench for the leaky-bucket monitor
module tb;
	localparam int CYC = 20; // Short sampling cycle
	logic clk, rstn;
	logic [13:0] bad, fail_in, alarm_out;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	int mismatches, checks_done, n, s;
	lbam_top #(.N_INPUTS(14), .CYCLE_CLKS(CYC)) uut (.clk, .rstn,
		.fail_in, .alarm_out, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
	lbam_src src (.clk, .bad, .fail_in);
	// Clock and edge counter
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk)
		n <= n + 1;
	// One write, both channels offered together
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// One read
	task automatic rd(input logic [11:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Read and compare data and response
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		rd(a);
		`CK("rdata", e, d)
		`CK("rresp", 2'h0, r)
	endtask
	// Write and expect an OKAY response
	task automatic wchk(input logic [11:0] a, input logic [31:0] v);
		wr(a, v);
		`CK("bresp", 2'h0, r)
	endtask
	// Wait until k edges past the sync point
	task automatic at(input int k);
		while (n != s + k) @(posedge clk);
	endtask
	// Alarm on input 0 only
	task automatic ac(input logic e);
		`CK("alarm", {13'h0, e}, alarm_out)
	endtask
	// Verdict
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard
	initial
	begin
		repeat (3000) @(posedge clk);
		mismatches++;
		close_out;
	end
	// Main sequence
	initial
	begin
		{rstn, bad, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rchk(12'h170, 32'h6);
		rchk(12'h174, 32'h4);
		rchk(12'h178, 32'h8);
		rchk(12'h17c, 32'h1);
		wchk(12'h170, 32'h0);
		rchk(12'h170, 32'h6);
		wchk(12'h178, 32'h0);
		rchk(12'h178, 32'h8);
		// Low byte lane off: write ignored
		s_axi_wstrb <= 4'he;
		wchk(12'h174, 32'h9);
		s_axi_wstrb <= 4'hf;
		rchk(12'h174, 32'h4);
		rd(12'h300);
		`CK("rresp", 2'h2, r)
		`CK("rdata", 32'h0, d)
		wr(12'h300, 32'h5);
		`CK("bresp", 2'h2, r)
		// Set 3, clear 1, cap 4, leak every clean cycle
		wchk(12'h170, 32'h3);
		wchk(12'h174, 32'h1);
		wchk(12'h178, 32'h4);
		wchk(12'h17c, 32'h0);
		rchk(12'h178, 32'h4);
		$display("test regs done");
		// Input 0 fails; sync to the alarm edge
		bad <= 14'h1;
		while (alarm_out[0] !== 1'b1) @(posedge clk);
		s = n;
		rchk(12'h200, 32'h1);
		// Status is read-only: a write leaves it alone
		wchk(12'h200, 32'h0);
		rchk(12'h200, 32'h1);
		at(60);
		bad <= 14'h0;
		at(120);
		ac(1'b1);
		at(140);
		ac(1'b0);
		bad <= 14'h1;
		at(160);
		ac(1'b0);
		bad <= 14'h0;
		at(180);
		ac(1'b1);
		$display("test bucket done");
		// Leak one per two clean cycles
		wchk(12'h17c, 32'h1);
		at(220);
		ac(1'b1);
		at(260);
		ac(1'b0);
		// Leak one per eight clean cycles; set level 1 raises alarm
		wchk(12'h17c, 32'h3);
		wchk(12'h170, 32'h1);
		rchk(12'h17c, 32'h3);
		at(280);
		ac(1'b1);
		at(400);
		ac(1'b1);
		at(420);
		ac(1'b0);
		$display("test decay done");
		// Reset in mid-run restores the defaults
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
		rchk(12'h170, 32'h6);
		rchk(12'h178, 32'h8);
		$display("test reset done");
		close_out;
	end
endmodule
